// ===== design/wuaf_pkg.sv
// package for the wake-up address former: register map, field positions,
// reset values, state encoding and timing counts.
// assumes a 32-bit apb slave with word-aligned registers.
package wuaf_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] REG_CFG = 12'h000;
    localparam logic [11:0] REG_BLK = 12'h004;
    localparam logic [11:0] REG_CTRL = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00C;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned CFG_WAKE_LSB = 0;
    localparam int unsigned CFG_PAGE_BIT = 16;
    localparam int unsigned CFG_PORT16_BIT = 17;
    localparam int unsigned CFG_BUS16_BIT = 18;
    localparam int unsigned CTRL_WAKE_EN_BIT = 0;
    localparam int unsigned CTRL_SOFT_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_SEEN_BIT = 1;
    localparam int unsigned STAT_CAPT_BIT = 2;

    // ****************************************************************
    // reset values and constants
    // ****************************************************************
    localparam logic CTRL_WAKE_EN_RST = 1'h1;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [15:0] WAKE_RST = 16'h0000;
    localparam int unsigned SEG_SHIFT = 4;
    localparam logic [3:0] SEG_OFFSET = 4'h0;
    localparam logic [3:0] PAGE_FIRST = 4'h0;
    localparam logic [3:0] PAGE_LAST = 4'hF;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [1:0] CAPT_SETTLE = 2'h3;

    // ****************************************************************
    // states, gray along capture -> idle -> fetch
    // ****************************************************************
    typedef enum logic [1:0] {
        WUAF_CAPT = 2'h0,
        WUAF_IDLE = 2'h1,
        WUAF_FETCH = 2'h3
    } wuaf_state_t;

endpackage : wuaf_pkg

// ===== design/wuaf_sync.sv
// two-flop synchroniser for a vector of slow, quasi-static pins.
// assumes each bit is sampled on its own; words must be stable for several
// clocks before their value is trusted as a whole.
`timescale 1ns/1ps
`default_nettype none
module wuaf_sync #(
    parameter int unsigned W = 1
) (
    input wire logic pclk,               // system clock
    input wire logic presetn,            // async reset, active low
    input wire logic [W-1:0] d,          // asynchronous input
    output logic [W-1:0] q               // synchronised output
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    if (W < 1) begin : g_bad_w
        $error("wuaf_sync: W must be at least 1");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : wuaf_sync
`default_nettype wire

// ===== design/wuaf_addr_form.sv
// combinational former of the 24-bit block address and the wake-up port
// number from a latched wake-up value and its mode settings.
// assumes its inputs are held constant by the caller.
`timescale 1ns/1ps
`default_nettype none
module wuaf_addr_form (
    input wire logic [15:0] wake_val,    // latched wake-up value
    input wire logic page_sel,           // page-select setting, 1 = last page
    input wire logic port16,             // 1 = 16-bit port addressing
    output logic [23:0] blk_addr,        // full system address of first block
    output logic [15:0] port_num         // wake-up port number
);
    logic [19:0] seg_addr;
    logic [3:0] page_nib;

    // segment times sixteen plus a zero offset
    assign seg_addr = {wake_val, wuaf_pkg::SEG_OFFSET};
    // fitted jumper sets all four top lines, absent clears them
    assign page_nib = page_sel ? wuaf_pkg::PAGE_LAST : wuaf_pkg::PAGE_FIRST;
    assign blk_addr = {page_nib, seg_addr};
    assign port_num = port16 ? wake_val : {8'h00, wake_val[7:0]};
endmodule : wuaf_addr_form
`default_nettype wire

// ===== design/wuaf_top.sv
// wake-up address former: latches the board straps, forms the address of
// the first communication block, watches host i/o writes for the wake-up
// port and hands a fetch request to the i/o processor.
// assumes straps and the host i/o pins are asynchronous; fetch_ack comes
// from logic on pclk. software sees the settings over apb.
//
// Contract
// - each of the sixteen address straps gives one bit, fitted reads one and absent reads zero.
// - the high strap group gives bits 15..8 and the low group bits 7..0 in descending order.
// - the first fetch goes to the start of the first block at the formed address.
// - the wake-up value is used as a segment with an offset of zero.
// - the 20-bit address is the wake-up value shifted left four places.
// - for 16- or 20-bit hosts any wake-up address is accepted without alignment limits.
// - with the page strap absent the top four address bits are zero.
// - with the page strap fitted the top four address bits are all one.
// - two further straps choose 8/16-bit port addressing and 8/16-bit data width.
// - a signal marked active low is asserted at the low level.
// - the port number is bits 7..0 with 8-bit port addressing, else bits 15..0.
// - an i/o write to the wake-up port starts a parameter fetch with no further host help.
// - with the width strap fitted transfers are 16-bit, otherwise 8-bit.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module wuaf_top (
    input wire logic pclk,                        // apb and board clock
    input wire logic presetn,                     // async reset, active low
    input wire logic [11:0] paddr,                // apb address
    input wire logic psel,                        // apb select
    input wire logic penable,                     // apb enable
    input wire logic pwrite,                      // apb direction
    input wire logic [31:0] pwdata,               // apb write data
    output logic [31:0] prdata,                   // apb read data
    output logic pready,                          // apb ready
    output logic pslverr,                         // apb error, unmapped address
    input wire logic [7:0] wake_high_byte_straps, // wake value bits 15..8
    input wire logic [7:0] wake_low_byte_straps,  // wake value bits 7..0
    input wire logic page_select_strap,           // fitted = last 1-mbyte page
    input wire logic port16_strap,                // fitted = 16-bit port addressing
    input wire logic bus16_strap,                 // fitted = 16-bit data transfers
    input wire logic [15:0] host_io_addr,         // host i/o port address
    input wire logic host_io_wr_n,                // host i/o write strobe, active low
    output logic fetch_req,                       // fetch request to the i/o processor
    output logic [23:0] fetch_addr,               // address of the first block
    output logic fetch_wide,                      // 1 = use 16-bit transfers
    input wire logic fetch_ack,                   // i/o processor took the request
    output logic port_wide                        // 1 = 16-bit port addressing active
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    localparam int unsigned PIN_W = 8 + 8 + 3 + 16 + 1;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_sync;
    logic [15:0] strap_wake_s;
    logic strap_page_s;
    logic strap_port16_s;
    logic strap_bus16_s;
    logic [15:0] io_addr_s;
    logic io_wr_n_s;

    // a fitted jumper already reads as one at the pin, no inversion needed
    assign pins_raw = {wake_high_byte_straps, wake_low_byte_straps,
                       page_select_strap, port16_strap, bus16_strap,
                       host_io_addr, host_io_wr_n};

    wuaf_sync #(
        .W(PIN_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pins_raw),
        .q(pins_sync)
    );

    assign strap_wake_s = pins_sync[35:20];
    assign strap_page_s = pins_sync[19];
    assign strap_port16_s = pins_sync[18];
    assign strap_bus16_s = pins_sync[17];
    assign io_addr_s = pins_sync[16:1];
    assign io_wr_n_s = pins_sync[0];

    // ****************************************************************
    // strap latch and state machine
    // ****************************************************************
    wuaf_pkg::wuaf_state_t state_r;
    wuaf_pkg::wuaf_state_t state_nxt;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic [15:0] wake_r;
    logic [15:0] wake_nxt;
    logic page_r;
    logic page_nxt;
    logic port16_r;
    logic port16_nxt;
    logic bus16_r;
    logic bus16_nxt;
    logic captured_r;
    logic captured_nxt;
    logic io_wr_n_d_r;
    logic io_wr_n_d_nxt;
    logic fetch_req_r;
    logic fetch_req_nxt;
    logic [23:0] fetch_addr_r;
    logic [23:0] fetch_addr_nxt;
    logic fetch_wide_r;
    logic fetch_wide_nxt;
    logic port_wide_r;
    logic port_wide_nxt;

    logic [23:0] blk_addr;
    logic [15:0] port_num;
    logic io_wr_fall;
    logic port_hit;
    logic host_wake;
    logic soft_wake;
    logic wake_en_r;

    wuaf_addr_form u_form (
        .wake_val(wake_r),
        .page_sel(page_r),
        .port16(port16_r),
        .blk_addr(blk_addr),
        .port_num(port_num)
    );

    // strobe is asserted low; its falling edge marks one host write
    assign io_wr_fall = io_wr_n_d_r & ~io_wr_n_s;
    // the address is sampled with the strobe edge, so the host must hold it
    // stable when the strobe falls; a glitchy bus could miss a wake
    assign port_hit = port16_r ? (io_addr_s == port_num)
                               : (io_addr_s[7:0] == port_num[7:0]);
    assign host_wake = io_wr_fall & port_hit & wake_en_r & captured_r;

    always_comb begin
        state_nxt = state_r;
        settle_nxt = settle_r;
        wake_nxt = wake_r;
        page_nxt = page_r;
        port16_nxt = port16_r;
        bus16_nxt = bus16_r;
        captured_nxt = captured_r;
        io_wr_n_d_nxt = io_wr_n_s;
        fetch_req_nxt = fetch_req_r;
        fetch_addr_nxt = fetch_addr_r;
        fetch_wide_nxt = fetch_wide_r;
        port_wide_nxt = port_wide_r;
        case (state_r)
            wuaf_pkg::WUAF_CAPT: begin
                // wait for the synchroniser to fill before trusting the straps
                if (settle_r == wuaf_pkg::CAPT_SETTLE) begin
                    wake_nxt = strap_wake_s;
                    page_nxt = strap_page_s;
                    port16_nxt = strap_port16_s;
                    bus16_nxt = strap_bus16_s;
                    captured_nxt = 1'b1;
                    state_nxt = wuaf_pkg::WUAF_IDLE;
                end else begin
                    settle_nxt = settle_r + 2'h1;
                end
            end
            wuaf_pkg::WUAF_IDLE: begin
                fetch_wide_nxt = bus16_r;
                port_wide_nxt = port16_r;
                if (host_wake || soft_wake) begin
                    fetch_addr_nxt = blk_addr;
                    fetch_req_nxt = 1'b1;
                    state_nxt = wuaf_pkg::WUAF_FETCH;
                end
            end
            wuaf_pkg::WUAF_FETCH: begin
                // request stands until taken; wakes meanwhile are merged
                if (fetch_ack) begin
                    fetch_req_nxt = 1'b0;
                    state_nxt = wuaf_pkg::WUAF_IDLE;
                end
            end
            default: begin
                fetch_req_nxt = 1'b0;
                state_nxt = wuaf_pkg::WUAF_CAPT;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= wuaf_pkg::WUAF_CAPT;
            settle_r <= 2'h0;
            wake_r <= wuaf_pkg::WAKE_RST;
            page_r <= 1'b0;
            port16_r <= 1'b0;
            bus16_r <= 1'b0;
            captured_r <= 1'b0;
            io_wr_n_d_r <= 1'b1;
            fetch_req_r <= 1'b0;
            fetch_addr_r <= 24'h00_0000;
            fetch_wide_r <= 1'b0;
            port_wide_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            settle_r <= settle_nxt;
            wake_r <= wake_nxt;
            page_r <= page_nxt;
            port16_r <= port16_nxt;
            bus16_r <= bus16_nxt;
            captured_r <= captured_nxt;
            io_wr_n_d_r <= io_wr_n_d_nxt;
            fetch_req_r <= fetch_req_nxt;
            fetch_addr_r <= fetch_addr_nxt;
            fetch_wide_r <= fetch_wide_nxt;
            port_wide_r <= port_wide_nxt;
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic wake_en_nxt;
    logic soft_r;
    logic soft_nxt;
    logic seen_r;
    logic seen_nxt;
    logic mapped;
    logic access;
    logic wr_commit;
    logic [31:0] rd_word;

    assign mapped = (paddr == wuaf_pkg::REG_CFG) || (paddr == wuaf_pkg::REG_BLK) ||
                    (paddr == wuaf_pkg::REG_CTRL) || (paddr == wuaf_pkg::REG_STAT);
    assign access = psel & penable;
    // one wait state: data and ready are both registered
    assign wr_commit = access & pready_r & pwrite & mapped;
    assign soft_wake = soft_r;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            wuaf_pkg::REG_CFG: begin
                rd_word[wuaf_pkg::CFG_WAKE_LSB +: 16] = wake_r;
                rd_word[wuaf_pkg::CFG_PAGE_BIT] = page_r;
                rd_word[wuaf_pkg::CFG_PORT16_BIT] = port16_r;
                rd_word[wuaf_pkg::CFG_BUS16_BIT] = bus16_r;
            end
            wuaf_pkg::REG_BLK: begin
                rd_word[23:0] = blk_addr;
            end
            wuaf_pkg::REG_CTRL: begin
                rd_word[wuaf_pkg::CTRL_WAKE_EN_BIT] = wake_en_r;
            end
            wuaf_pkg::REG_STAT: begin
                rd_word[wuaf_pkg::STAT_BUSY_BIT] = fetch_req_r;
                rd_word[wuaf_pkg::STAT_SEEN_BIT] = seen_r;
                rd_word[wuaf_pkg::STAT_CAPT_BIT] = captured_r;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        wake_en_nxt = wake_en_r;
        soft_nxt = 1'b0;
        seen_nxt = seen_r;
        if (access && !pready_r) begin
            pready_nxt = 1'b1;
            pslverr_nxt = ~mapped;
            prdata_nxt = (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
        end
        if (wr_commit && (paddr == wuaf_pkg::REG_CTRL)) begin
            wake_en_nxt = pwdata[wuaf_pkg::CTRL_WAKE_EN_BIT];
            // soft wake is ignored before straps are latched
            soft_nxt = pwdata[wuaf_pkg::CTRL_SOFT_BIT] & captured_r;
        end
        if (wr_commit && (paddr == wuaf_pkg::REG_STAT) && pwdata[wuaf_pkg::STAT_SEEN_BIT]) begin
            seen_nxt = 1'b0;
        end
        // a wake in the clearing cycle still leaves the flag set
        if (host_wake) begin
            seen_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= wuaf_pkg::RDATA_RST;
            wake_en_r <= wuaf_pkg::CTRL_WAKE_EN_RST;
            soft_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
            wake_en_r <= wake_en_nxt;
            soft_r <= soft_nxt;
            seen_r <= seen_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign fetch_req = fetch_req_r;
    assign fetch_addr = fetch_addr_r;
    assign fetch_wide = fetch_wide_r;
    assign port_wide = port_wide_r;
endmodule : wuaf_top
`default_nettype wire

// ===== dv/wuaf_monitor.sv
// checker for the wake-up address former: fetch address, modes and apb timing.
// assumes the straps sit at their latched values whenever a fetch starts.
`timescale 1ns/1ps
`default_nettype none
module wuaf_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    input wire logic [7:0] wake_high_byte_straps, // wake bits 15..8
    input wire logic [7:0] wake_low_byte_straps, // wake bits 7..0
    input wire logic page_select_strap, // page strap
    input wire logic port16_strap, // port width strap
    input wire logic bus16_strap, // data width strap
    input wire logic host_io_wr_n, // host write, active low
    input wire logic fetch_req, // fetch request
    input wire logic [23:0] fetch_addr, // first block address
    input wire logic fetch_wide, // 16-bit transfers
    input wire logic fetch_ack, // request taken
    input wire logic port_wide // 16-bit port addressing
);
    // ****************************************************************
    // properties
    // ****************************************************************
    wire logic soft_go = psel && penable && pready && pwrite &&
        (paddr == wuaf_pkg::REG_CTRL) && pwdata[wuaf_pkg::CTRL_SOFT_BIT];
    default clocking mcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // a strobe may be held two or more clocks, so two depths are allowed
    sequence host_cause;
        $past(!host_io_wr_n, 2) || $past(!host_io_wr_n, 3);
    endsequence
    sequence soft_cause;
        $past(soft_go, 2) || $past(soft_go, 3);
    endsequence
    AST_SHIFT: assert property ($rose(fetch_req) |-> fetch_addr[19:0] ==
        {wake_high_byte_straps, wake_low_byte_straps, wuaf_pkg::SEG_OFFSET})
        else $error("fetch address does not follow the wake straps");
    AST_PAGE: assert property ($rose(fetch_req) |-> fetch_addr[23:20] ==
        (page_select_strap ? wuaf_pkg::PAGE_LAST : wuaf_pkg::PAGE_FIRST))
        else $error("page nibble does not follow the page strap");
    AST_MODES: assert property ($rose(fetch_req) |->
        fetch_wide == bus16_strap && port_wide == port16_strap)
        else $error("width modes do not follow the straps");
    AST_CAUSE: assert property ($rose(fetch_req) |-> host_cause or soft_cause)
        else $error("fetch request without a wake");
    AST_HOLD: assert property (fetch_req && !fetch_ack |=>
        fetch_req && $stable(fetch_addr))
        else $error("fetch request dropped before it was taken");
    AST_DROP: assert property (fetch_req && fetch_ack |=> !fetch_req)
        else $error("fetch request stays after it was taken");
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not after one wait state");
    AST_RELEASE: assert property ($rose(presetn) |->
        (!fetch_req && fetch_addr == 24'h000000) [*4])
        else $error("fetch activity right after reset release");
endmodule : wuaf_monitor

bind wuaf_top wuaf_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .wake_high_byte_straps(wake_high_byte_straps), .wake_low_byte_straps(wake_low_byte_straps),
    .page_select_strap(page_select_strap), .port16_strap(port16_strap),
    .bus16_strap(bus16_strap), .host_io_wr_n(host_io_wr_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_wide(fetch_wide), .fetch_ack(fetch_ack),
    .port_wide(port_wide)
);
`default_nettype wire

// ===== dv/wuaf_host_model.sv
// host cpu model: performs i/o writes to the board's wake-up port.
// assumes the caller keeps the page strap absent on hosts without 24-bit lines.
`timescale 1ns/1ps
`default_nettype none
module wuaf_host_model (
    input wire logic pclk, // board clock the strobes are aligned to
    output logic [15:0] host_io_addr, // i/o port address
    output logic host_io_wr_n // write strobe, active low
);
    initial begin
        host_io_addr = 16'h0000;
        host_io_wr_n = 1'b1;
    end
    // low_cycles lets a scenario be prompt (2) or slow (more)
    task automatic io_write(input logic [15:0] port, input int low_cycles);
        @(posedge pclk);
        host_io_addr <= port;
        host_io_wr_n <= 1'b0;
        repeat (low_cycles) @(posedge pclk);
        host_io_wr_n <= 1'b1;
        repeat (2) @(posedge pclk);
        // a released bus shows no stale port number
        host_io_addr <= ~port;
    endtask : io_write
endmodule : wuaf_host_model
`default_nettype wire

// ===== dv/wuaf_top_tb.sv
// testbench for the wake-up address former: straps, host wakes, apb registers.
// assumes the checker is bound to the top and the host model drives the i/o pins.
`timescale 1ns/1ps
`default_nettype none
module wuaf_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic page_select_strap, port16_strap, bus16_strap, host_io_wr_n;
    logic fetch_req, fetch_wide, fetch_ack, port_wide;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] wake_high_byte_straps, wake_low_byte_straps;
    logic [15:0] host_io_addr;
    logic [23:0] fetch_addr;
    int failures = 0;
    int comparisons = 0;

    wuaf_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_high_byte_straps(wake_high_byte_straps),
        .wake_low_byte_straps(wake_low_byte_straps), .page_select_strap(page_select_strap),
        .port16_strap(port16_strap), .bus16_strap(bus16_strap),
        .host_io_addr(host_io_addr), .host_io_wr_n(host_io_wr_n), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_wide(fetch_wide), .fetch_ack(fetch_ack),
        .port_wide(port_wide));
    wuaf_host_model host (.pclk(pclk), .host_io_addr(host_io_addr),
        .host_io_wr_n(host_io_wr_n));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the answer counts only at a rising edge that sees pready high
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task boot(input logic [15:0] w, input logic pg, input logic p16, input logic b16);
        @(posedge pclk);
        {wake_high_byte_straps, wake_low_byte_straps} <= w;
        {page_select_strap, port16_strap, bus16_strap} <= {pg, p16, b16};
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : boot
    task wait_req(input logic want);
        int n;
        n = 0;
        while (fetch_req !== 1'b1 && n < 12) begin
            @(negedge pclk);
            n++;
        end
        chk({31'h0, fetch_req}, {31'h0, want});
    endtask : wait_req
    task take_fetch(input int delay);
        repeat (delay) @(posedge pclk);
        fetch_ack <= 1'b1;
        @(posedge pclk);
        fetch_ack <= 1'b0;
        @(negedge pclk);
        chk({31'h0, fetch_req}, 32'h0);
    endtask : take_fetch

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task sc_straps_a;
        boot(16'hA5C3, 1'b0, 1'b0, 1'b1);
        apb(1'b0, wuaf_pkg::REG_CFG, 32'h0);
        chk(rd, 32'h0004_A5C3);
        apb(1'b0, wuaf_pkg::REG_BLK, 32'h0);
        chk(rd, 32'h000A_5C30);
        apb(1'b0, wuaf_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, wuaf_pkg::REG_STAT, 32'h0);
        chk(rd, 32'h0000_0004);
        chk({30'h0, fetch_wide, port_wide}, 32'h2);
        @(posedge pclk);
        {wake_high_byte_straps, wake_low_byte_straps} <= 16'h5A3C;
        page_select_strap <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, wuaf_pkg::REG_CFG, 32'h0);
        chk(rd, 32'h0004_A5C3);
        {wake_high_byte_straps, wake_low_byte_straps} <= 16'hA5C3;
        page_select_strap <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : sc_straps_a
    task sc_wake_8bit;
        host.io_write(16'h12C3, 3);
        wait_req(1'b1);
        chk({8'h0, fetch_addr}, 32'h000A_5C30);
        apb(1'b0, wuaf_pkg::REG_STAT, 32'h0);
        chk(rd, 32'h0000_0007);
        take_fetch(0);
        apb(1'b1, wuaf_pkg::REG_STAT, 32'h2);
        apb(1'b0, wuaf_pkg::REG_STAT, 32'h0);
        chk(rd, 32'h0000_0004);
    endtask : sc_wake_8bit
    task sc_refuse;
        host.io_write(16'h00C2, 2);
        wait_req(1'b0);
        apb(1'b1, wuaf_pkg::REG_CTRL, 32'h0);
        apb(1'b0, wuaf_pkg::REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        host.io_write(16'h00C3, 2);
        wait_req(1'b0);
        apb(1'b1, wuaf_pkg::REG_CTRL, 32'h3);
        wait_req(1'b1);
        chk({8'h0, fetch_addr}, 32'h000A_5C30);
        take_fetch(4);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
    endtask : sc_refuse
    task sc_straps_b;
        boot(16'h5A3C, 1'b1, 1'b1, 1'b0);
        host.io_write(16'h003C, 4);
        wait_req(1'b0);
        host.io_write(16'h5A3C, 4);
        wait_req(1'b1);
        chk({8'h0, fetch_addr}, 32'h00F5_A3C0);
        chk({30'h0, fetch_wide, port_wide}, 32'h1);
        take_fetch(5);
    endtask : sc_straps_b

    task close_out;
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    initial begin
        {presetn, psel, penable, pwrite, fetch_ack} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        {wake_high_byte_straps, wake_low_byte_straps} = 16'h0000;
        {page_select_strap, port16_strap, bus16_strap} = 3'h0;
        sc_straps_a();
        sc_wake_8bit();
        sc_refuse();
        sc_straps_b();
        close_out();
    end

    // the whole run needs well under a thousand clocks
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        close_out();
    end
endmodule : wuaf_top_tb
`default_nettype wire
